// ---- logic/dbm_fifo.sv ----
`timescale 1ns/1ps
module dbm_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	// depth must be a power of two: pointers wrap naturally
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = count != FULL;
	assign out_valid = count != '0;
	assign out_data = store[rd_ptr];

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			wr_ptr <= wr_ptr + AW'(push);
			rd_ptr <= rd_ptr + AW'(pop);
			count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end

	always_ff @(posedge clock)
	begin
		if (push)
			store[wr_ptr] <= in_data;
	end
endmodule : dbm_fifo

// ---- logic/dbm_pkg.sv ----
package dbm_pkg;
	localparam int CLK_PERIOD_NS = 5;
	localparam int RCLK_HALF_NS = 40;
	localparam int RCLK_HALF_CYC = (RCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BANK_BUSY_NS = 20;
	localparam int BANK_BUSY_CYC = (BANK_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BANKS = 8;
	localparam int BANK_W = 3;
	localparam int ADDR_W = 6;
	localparam int COL_W = 3;
	localparam int ROW_W = ADDR_W - COL_W;
	localparam int DATA_W = 9;
	localparam int RFIFO_DEPTH = 32;
	localparam int CNT_W = 4;
	localparam int BURST_FIELD_LSB = 0;
	localparam logic [1:0] BURST_CODE_2 = 2'h0;
	localparam logic [1:0] BURST_CODE_4 = 2'h1;
	localparam logic [1:0] BURST_CODE_8 = 2'h2;
	localparam logic [1:0] BURST_CODE_BAD = 2'h3;
	localparam logic [1:0] BURST_CODE_RST = BURST_CODE_2;
	localparam logic [CNT_W-1:0] BUSY_LOAD = CNT_W'(BANK_BUSY_CYC);
	localparam logic [CNT_W-1:0] RCLK_LOAD = CNT_W'(RCLK_HALF_CYC - 1);

	typedef struct packed {
		logic cs_n;
		logic we_n;
		logic ref_n;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
	} dbm_cmd_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic mask;
	} dbm_wword_t;

	typedef enum logic [1:0] {
		DBM_IDLE = 2'h1,
		DBM_BURST = 2'h2
	} dbm_eng_t;

	function automatic logic [CNT_W-1:0] burst_words(input logic [1:0] code);
		case (code)
			BURST_CODE_4: burst_words = 4'h4;
			BURST_CODE_8: burst_words = 4'h8;
			default: burst_words = 4'h2;
		endcase
	endfunction : burst_words

	// column wraps inside the aligned burst block
	function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] base,
		input logic [COL_W-1:0] idx, input logic [1:0] code);
		logic [COL_W-1:0] wrap;
		logic [COL_W-1:0] col;
		wrap = COL_W'(burst_words(code) - 4'h1);
		col = base[COL_W-1:0] + idx;
		burst_addr = {base[ADDR_W-1:COL_W], (base[COL_W-1:0] & ~wrap) | (col & wrap)};
	endfunction : burst_addr
endpackage : dbm_pkg

// ---- logic/dbm_sync2.sv ----
`timescale 1ns/1ps
module dbm_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			meta <= '0;
			q <= '0;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : dbm_sync2

// ---- logic/dbm_top.sv ----
`timescale 1ns/1ps
module dbm_top (
	input wire logic clock,
	input wire logic nrst,
	input wire logic command_clock_pair,
	input wire dbm_pkg::dbm_cmd_t cmd,
	input wire logic write_data_clock,
	input wire logic [dbm_pkg::DATA_W-1:0] dq_in,
	input wire logic write_byte_mask,
	output logic read_data_clock,
	output logic [dbm_pkg::DATA_W-1:0] dq_out,
	output logic dq_oe,
	output logic read_valid_flag,
	output logic bank_conflict,
	output logic [dbm_pkg::BANK_W-1:0] refresh_bank,
	output logic [dbm_pkg::ROW_W-1:0] refresh_row
);
	localparam int CMD_W = $bits(dbm_pkg::dbm_cmd_t);
	localparam int WW_W = $bits(dbm_pkg::dbm_wword_t);
	localparam int MEM_AW = dbm_pkg::BANK_W + dbm_pkg::ADDR_W;

	logic [CMD_W:0] csync;
	logic [WW_W:0] wsync;
	dbm_pkg::dbm_cmd_t cmd_s;
	dbm_pkg::dbm_wword_t wword_s;
	logic cclk_s;
	logic cclk_d;
	logic wclk_s;
	logic wclk_d;
	logic [1:0] burst_code;
	logic [dbm_pkg::CNT_W-1:0] bank_busy [dbm_pkg::BANKS];
	logic [dbm_pkg::ROW_W-1:0] ref_rows [dbm_pkg::BANKS];
	logic [dbm_pkg::DATA_W-1:0] mem [1 << MEM_AW];
	dbm_pkg::dbm_eng_t rd_state;
	dbm_pkg::dbm_eng_t next_rd_state;
	dbm_pkg::dbm_eng_t wr_state;
	dbm_pkg::dbm_eng_t next_wr_state;
	logic [dbm_pkg::BANK_W-1:0] rd_bank;
	logic [dbm_pkg::ADDR_W-1:0] rd_addr;
	logic [dbm_pkg::COL_W-1:0] rd_idx;
	logic [dbm_pkg::CNT_W-1:0] rd_left;
	logic [1:0] rd_code;
	logic [dbm_pkg::BANK_W-1:0] wr_bank;
	logic [dbm_pkg::ADDR_W-1:0] wr_addr;
	logic [dbm_pkg::COL_W-1:0] wr_idx;
	logic [dbm_pkg::CNT_W-1:0] wr_left;
	logic [1:0] wr_code;
	logic [dbm_pkg::CNT_W-1:0] rclk_cnt;
	logic push_ready;
	logic fifo_valid;
	logic [dbm_pkg::DATA_W-1:0] fifo_data;

	// pins and both link clocks cross in through two flops before any use
	dbm_sync2 #(.WIDTH(CMD_W + 1)) u_cmd_sync (
		.clock(clock),
		.nrst(nrst),
		.d({command_clock_pair, cmd}),
		.q(csync)
	);

	dbm_sync2 #(.WIDTH(WW_W + 1)) u_wr_sync (
		.clock(clock),
		.nrst(nrst),
		.d({write_data_clock, dq_in, write_byte_mask}),
		.q(wsync)
	);

	assign cclk_s = csync[CMD_W];
	assign cmd_s = dbm_pkg::dbm_cmd_t'(csync[CMD_W-1:0]);
	assign wclk_s = wsync[WW_W];
	assign wword_s = dbm_pkg::dbm_wword_t'(wsync[WW_W-1:0]);

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			cclk_d <= 1'b0;
			wclk_d <= 1'b0;
		end
		else
		begin
			cclk_d <= cclk_s;
			wclk_d <= wclk_s;
		end
	end

	// command decode, rising edge of the command clock only
	wire cmd_take = cclk_s && !cclk_d;
	wire wr_edge = wclk_s ^ wclk_d;
	wire sel = cmd_take && !cmd_s.cs_n;
	wire is_mode = sel && !cmd_s.we_n && !cmd_s.ref_n;
	wire is_wr = sel && !cmd_s.we_n && cmd_s.ref_n;
	wire is_ref = sel && cmd_s.we_n && !cmd_s.ref_n;
	wire is_rd = sel && cmd_s.we_n && cmd_s.ref_n;
	wire [1:0] mode_field = cmd_s.addr[dbm_pkg::BURST_FIELD_LSB +: 2];
	wire mode_ok = is_mode && mode_field != dbm_pkg::BURST_CODE_BAD;
	wire bank_free = bank_busy[cmd_s.bank] == '0;
	wire rd_go = is_rd && bank_free && rd_state == dbm_pkg::DBM_IDLE;
	wire wr_go = is_wr && bank_free && wr_state == dbm_pkg::DBM_IDLE;
	wire ref_go = is_ref && bank_free;
	wire start_any = rd_go || wr_go || ref_go;
	wire refuse = (is_rd || is_wr || is_ref) && !start_any;
	wire [dbm_pkg::CNT_W-1:0] burst_now = dbm_pkg::burst_words(burst_code);

	// read engine feeds the fifo one word a cycle; a full fifo stalls it
	wire push_valid = rd_state == dbm_pkg::DBM_BURST;
	wire rd_step = push_valid && push_ready;
	wire rd_last = rd_step && rd_left == 4'h1;
	wire [MEM_AW-1:0] rd_maddr = {rd_bank, dbm_pkg::burst_addr(rd_addr, rd_idx, rd_code)};
	wire [dbm_pkg::DATA_W-1:0] push_data = mem[rd_maddr];

	// write engine takes one word per write clock edge
	wire wr_step = wr_state == dbm_pkg::DBM_BURST && wr_edge;
	wire wr_last = wr_step && wr_left == 4'h1;
	wire mem_we = wr_step && !wword_s.mask;
	wire [MEM_AW-1:0] wr_maddr = {wr_bank, dbm_pkg::burst_addr(wr_addr, wr_idx, wr_code)};

	wire rclk_tick = rclk_cnt == '0;

	// mode register: an unsupported code leaves the old length in place
	always_ff @(posedge clock)
	begin
		if (!nrst)
			burst_code <= dbm_pkg::BURST_CODE_RST;
		else if (mode_ok)
			burst_code <= mode_field;
	end

	always_ff @(posedge clock)
	begin
		for (int b = 0; b < dbm_pkg::BANKS; b++)
		begin
			if (!nrst)
			begin
				bank_busy[b] <= '0;
				ref_rows[b] <= '0;
			end
			else
			begin
				if (start_any && cmd_s.bank == (dbm_pkg::BANK_W)'(b))
					bank_busy[b] <= dbm_pkg::BUSY_LOAD;
				else if (bank_busy[b] != '0)
					bank_busy[b] <= bank_busy[b] - 4'h1;
				if (ref_go && cmd_s.bank == (dbm_pkg::BANK_W)'(b))
					ref_rows[b] <= ref_rows[b] + 3'h1;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			bank_conflict <= 1'b0;
			refresh_bank <= '0;
			refresh_row <= '0;
		end
		else
		begin
			bank_conflict <= refuse;
			if (ref_go)
			begin
				refresh_bank <= cmd_s.bank;
				refresh_row <= ref_rows[cmd_s.bank];
			end
		end
	end

	always_comb
	begin
		case (rd_state)
			dbm_pkg::DBM_IDLE: next_rd_state = rd_go ? dbm_pkg::DBM_BURST : dbm_pkg::DBM_IDLE;
			dbm_pkg::DBM_BURST: next_rd_state = rd_last ? dbm_pkg::DBM_IDLE : dbm_pkg::DBM_BURST;
			default: next_rd_state = dbm_pkg::DBM_IDLE;
		endcase
		case (wr_state)
			dbm_pkg::DBM_IDLE: next_wr_state = wr_go ? dbm_pkg::DBM_BURST : dbm_pkg::DBM_IDLE;
			dbm_pkg::DBM_BURST: next_wr_state = wr_last ? dbm_pkg::DBM_IDLE : dbm_pkg::DBM_BURST;
			default: next_wr_state = dbm_pkg::DBM_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			rd_state <= dbm_pkg::DBM_IDLE;
			rd_bank <= '0;
			rd_addr <= '0;
			rd_idx <= '0;
			rd_left <= '0;
			rd_code <= dbm_pkg::BURST_CODE_RST;
		end
		else
		begin
			rd_state <= next_rd_state;
			if (rd_go)
			begin
				rd_bank <= cmd_s.bank;
				rd_addr <= cmd_s.addr;
				rd_idx <= '0;
				rd_left <= burst_now;
				rd_code <= burst_code;
			end
			else if (rd_step)
			begin
				rd_idx <= rd_idx + 3'h1;
				rd_left <= rd_left - 4'h1;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			wr_state <= dbm_pkg::DBM_IDLE;
			wr_bank <= '0;
			wr_addr <= '0;
			wr_idx <= '0;
			wr_left <= '0;
			wr_code <= dbm_pkg::BURST_CODE_RST;
		end
		else
		begin
			wr_state <= next_wr_state;
			if (wr_go)
			begin
				wr_bank <= cmd_s.bank;
				wr_addr <= cmd_s.addr;
				wr_idx <= '0;
				wr_left <= burst_now;
				wr_code <= burst_code;
			end
			else if (wr_step)
			begin
				wr_idx <= wr_idx + 3'h1;
				wr_left <= wr_left - 4'h1;
			end
		end
	end

	// storage carries no reset; contents are undefined until written
	always_ff @(posedge clock)
	begin
		if (mem_we)
			mem[wr_maddr] <= wword_s.data;
	end

	dbm_fifo #(.WIDTH(dbm_pkg::DATA_W), .DEPTH(dbm_pkg::RFIFO_DEPTH)) u_rd_fifo (
		.clock(clock),
		.nrst(nrst),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_data),
		.out_valid(fifo_valid),
		.out_ready(rclk_tick),
		.out_data(fifo_data)
	);

	// read clock runs free; a word leaves on each of its edges, so two per period
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			rclk_cnt <= dbm_pkg::RCLK_LOAD;
			read_data_clock <= 1'b0;
			read_valid_flag <= 1'b0;
			dq_oe <= 1'b0;
			dq_out <= '0;
		end
		else
		begin
			rclk_cnt <= rclk_tick ? dbm_pkg::RCLK_LOAD : rclk_cnt - 4'h1;
			read_data_clock <= read_data_clock ^ rclk_tick;
			if (rclk_tick)
			begin
				read_valid_flag <= fifo_valid;
				dq_oe <= fifo_valid;
				if (fifo_valid)
					dq_out <= fifo_data;
			end
		end
	end

	default clocking @(posedge clock);
	endclocking
	default disable iff (!nrst);

	bank_refuse_a:
	assert property ((is_rd || is_wr || is_ref) && !bank_free |=> bank_conflict)
		else $error("command to busy bank not refused");
	bank_load_a:
	assert property (start_any |=> bank_busy[$past(cmd_s.bank)] == dbm_pkg::BUSY_LOAD)
		else $error("bank busy timer not loaded");
	rclk_period_a:
	assert property ($changed(read_data_clock) |=> $stable(read_data_clock)[*7]
		##1 $changed(read_data_clock))
		else $error("read data clock half period wrong");
	read_align_a:
	assert property ($changed(dq_out) |-> $changed(read_data_clock))
		else $error("read data moved off a read clock edge");
	cmd_edge_a:
	assert property ($changed(burst_code) |-> $past(cmd_take))
		else $error("mode changed outside command clock edge");
	write_both_a:
	assert property (wr_state == dbm_pkg::DBM_BURST && $fell(wclk_s) && !wword_s.mask
		|=> mem[$past(wr_maddr)] == $past(wword_s.data)) else $error("falling write edge lost");
	write_count_a:
	assert property (wr_step |=> wr_left == $past(wr_left) - 4'h1)
		else $error("write word count not advanced");
	burst_len_a:
	assert property (rd_go |=> rd_state == dbm_pkg::DBM_BURST && rd_left == $past(burst_now))
		else $error("read burst length not taken from mode");
	refresh_row_a:
	assert property (ref_go |=> refresh_row == $past(ref_rows[cmd_s.bank])
		##1 ref_rows[$past(cmd_s.bank, 2)] == $past(refresh_row) + 3'h1)
		else $error("internal refresh row wrong");
	valid_flag_a:
	assert property (fifo_valid && rclk_tick |=> read_valid_flag && dq_oe
		&& dq_out == $past(fifo_data))
		else $error("read word not flagged on bus");
	mask_hold_a:
	assert property (wr_step && wword_s.mask |=> mem[$past(wr_maddr)] == $past(mem[wr_maddr]))
		else $error("masked word was written");

	burst8_c: cover property (rd_go && burst_now == 4'h8);
	masked_c: cover property (wr_step && wword_s.mask);
	refresh_c: cover property (ref_go);
	full_c: cover property (push_valid && !push_ready);
endmodule : dbm_top

// ---- tb/dbm_ctl_model.sv ----
`timescale 1ns/1ps
module dbm_ctl_model (
	input wire logic clock,
	input wire logic bank_conflict,
	output logic command_clock_pair,
	output dbm_pkg::dbm_cmd_t cmd,
	output logic write_data_clock,
	output logic [dbm_pkg::DATA_W-1:0] dq_in,
	output logic write_byte_mask
);
	initial
	begin
		command_clock_pair = 1'b0;
		cmd = '1;
		write_data_clock = 1'b0;
		dq_in = '0;
		write_byte_mask = 1'b0;
	end

	// one command per 160 ns frame; the clock pair stands still between frames
	task automatic send_cmd(input dbm_pkg::dbm_cmd_t c, output logic refused);
		refused = 1'b0;
		@(negedge clock);
		cmd = c;
		repeat (8) @(negedge clock);
		command_clock_pair = 1'b1;
		repeat (16)
		begin
			@(negedge clock);
			refused = refused | bank_conflict;
		end
		command_clock_pair = 1'b0;
		// released pins show a changed pattern so a stale command is never reused
		cmd = {1'b1, ~c[10:0]};
		repeat (7) @(negedge clock);
	endtask : send_cmd

	// one word per write clock edge, held 8 cycles either side of it
	task automatic send_words(input logic [8:0] w[$], input logic [7:0] m);
		foreach (w[i])
		begin
			@(negedge clock);
			dq_in = w[i];
			write_byte_mask = m[i];
			repeat (8) @(negedge clock);
			write_data_clock = ~write_data_clock;
			repeat (7) @(negedge clock);
		end
		@(negedge clock);
		dq_in = ~dq_in;
		write_byte_mask = ~write_byte_mask;
	endtask : send_words
endmodule : dbm_ctl_model

// ---- tb/ddr_burst_memory_interface_bench.sv ----
`timescale 1ns/1ps
module ddr_burst_memory_interface_bench;
	logic clock;
	logic nrst;
	logic command_clock_pair;
	dbm_pkg::dbm_cmd_t cmd;
	logic write_data_clock;
	logic [dbm_pkg::DATA_W-1:0] dq_in;
	logic write_byte_mask;
	logic read_data_clock;
	logic [dbm_pkg::DATA_W-1:0] dq_out;
	logic dq_oe;
	logic read_valid_flag;
	logic bank_conflict;
	logic [dbm_pkg::BANK_W-1:0] refresh_bank;
	logic [dbm_pkg::ROW_W-1:0] refresh_row;
	logic [8:0] mem [0:511];
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;
	int burst_len = 2;

	dbm_top dut (.clock(clock), .nrst(nrst), .command_clock_pair(command_clock_pair),
		.cmd(cmd), .write_data_clock(write_data_clock), .dq_in(dq_in),
		.write_byte_mask(write_byte_mask), .read_data_clock(read_data_clock),
		.dq_out(dq_out), .dq_oe(dq_oe), .read_valid_flag(read_valid_flag),
		.bank_conflict(bank_conflict), .refresh_bank(refresh_bank),
		.refresh_row(refresh_row));

	dbm_ctl_model ctl (.clock(clock), .bank_conflict(bank_conflict),
		.command_clock_pair(command_clock_pair), .cmd(cmd),
		.write_data_clock(write_data_clock), .dq_in(dq_in),
		.write_byte_mask(write_byte_mask));

	initial clock = 1'b0;
	always #2.5 clock = ~clock;

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	// a hang costs a mismatch; the whole run needs about 1500 cycles
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	function automatic dbm_pkg::dbm_cmd_t mk(input logic w, input logic r,
		input logic [2:0] b, input logic [5:0] a);
		mk = {1'b0, w, r, b, a};
	endfunction : mk

	// column wraps inside the block aligned to the burst length
	function automatic logic [5:0] baddr(input logic [5:0] base, input int i);
		logic [2:0] k;
		k = 3'(burst_len - 1);
		baddr = {base[5:3], (base[2:0] & ~k) | ((base[2:0] + 3'(i)) & k)};
	endfunction : baddr

	task automatic do_cmd(input dbm_pkg::dbm_cmd_t c, input logic exp);
		logic r;
		ctl.send_cmd(c, r);
		check("conflict", r, exp);
	endtask : do_cmd

	task automatic set_burst(input int n);
		logic [1:0] code;
		code = n == 8 ? dbm_pkg::BURST_CODE_8
			: (n == 4 ? dbm_pkg::BURST_CODE_4 : dbm_pkg::BURST_CODE_2);
		do_cmd(mk(1'b0, 1'b0, 3'h0, {4'h0, code}), 1'b0);
		burst_len = n;
	endtask : set_burst

	// intr issues a write to bank nb while this burst still waits for words
	task automatic wr(input logic [2:0] b, input logic [5:0] base, input logic [8:0] seed,
		input logic [7:0] m, input logic intr, input logic [2:0] nb);
		logic [8:0] w[$];
		for (int i = 0; i < burst_len; i++)
		begin
			w.push_back(seed + 9'(i * 37));
			if (!m[i])
				mem[{b, baddr(base, i)}] = w[i];
		end
		do_cmd(mk(1'b0, 1'b1, b, base), 1'b0);
		if (intr)
			do_cmd(mk(1'b0, 1'b1, nb, base), 1'b1);
		ctl.send_words(w, m);
	endtask : wr

	task automatic collect(input logic [8:0] q[$]);
		logic last;
		int t;
		foreach (q[i])
		begin
			t = 0;
			do
			begin
				last = read_data_clock;
				@(negedge clock);
				t++;
			end
			while (!(read_data_clock !== last && read_valid_flag === 1'b1) && t < 300);
			check("read_wait", 16'(t < 300), 16'h1);
			check("dq_out", dq_out, q[i]);
			check("dq_oe", dq_oe, 1'b1);
		end
		repeat (8) @(negedge clock);
		check("valid_idle", read_valid_flag, 1'b0);
	endtask : collect

	task automatic rd(input logic [2:0] b, input logic [5:0] base);
		logic [8:0] q[$];
		for (int i = 0; i < burst_len; i++)
			q.push_back(mem[{b, baddr(base, i)}]);
		fork
			do_cmd(mk(1'b1, 1'b1, b, base), 1'b0);
			collect(q);
		join
	endtask : rd

	task automatic t_reset();
		logic l;
		int t;
		check("dq_oe", dq_oe, 1'b0);
		check("refresh_row", refresh_row, 3'h0);
		t = 0;
		l = read_data_clock;
		while (read_data_clock === l && t < 40)
		begin
			@(negedge clock);
			t++;
		end
		l = read_data_clock;
		t = 0;
		while (read_data_clock === l && t < 40)
		begin
			@(negedge clock);
			t++;
		end
		check("rclk_half", 16'(t), 16'h8);
	endtask : t_reset

	task automatic t_bursts();
		for (int n = 2; n <= 8; n *= 2)
		begin
			set_burst(n);
			wr(3'(n - 1), 6'h0D, 9'(n * 5), 8'h00, 1'b0, 3'h0);
			rd(3'(n - 1), 6'h0D);
		end
	endtask : t_bursts

	task automatic t_mask();
		set_burst(4);
		// an unsupported length code must leave the burst of four in place
		do_cmd(mk(1'b0, 1'b0, 3'h0, 6'h03), 1'b0);
		wr(3'h7, 6'h12, 9'h100, 8'h00, 1'b0, 3'h0);
		wr(3'h7, 6'h12, 9'h055, 8'h06, 1'b0, 3'h0);
		rd(3'h7, 6'h12);
	endtask : t_mask

	// reads to two banks back to back, both bursts must come out in order
	task automatic t_banks();
		logic [8:0] q[$];
		set_burst(2);
		wr(3'h1, 6'h20, 9'h0C1, 8'h00, 1'b0, 3'h0);
		wr(3'h6, 6'h21, 9'h13A, 8'h00, 1'b0, 3'h0);
		for (int i = 0; i < 2; i++)
			q.push_back(mem[{3'h1, baddr(6'h20, i)}]);
		for (int i = 0; i < 2; i++)
			q.push_back(mem[{3'h6, baddr(6'h21, i)}]);
		fork
			begin
				do_cmd(mk(1'b1, 1'b1, 3'h1, 6'h20), 1'b0);
				do_cmd(mk(1'b1, 1'b1, 3'h6, 6'h21), 1'b0);
			end
			collect(q);
		join
		wr(3'h2, 6'h3F, 9'h1F0, 8'h00, 1'b1, 3'h4);
		rd(3'h2, 6'h3F);
	endtask : t_banks

	// refresh rate is far below the real interval; only bank and row sequencing is judged
	task automatic t_refresh();
		logic [2:0] bk [4] = '{3'h3, 3'h3, 3'h5, 3'h3};
		logic [2:0] rw [4] = '{3'h0, 3'h1, 3'h0, 3'h2};
		// a deselected refresh to bank 3 must leave every refresh output alone
		do_cmd(12'hCC0, 1'b0);
		check("refresh_bank", refresh_bank, 3'h0);
		check("refresh_row", refresh_row, 3'h0);
		foreach (bk[i])
		begin
			do_cmd(mk(1'b1, 1'b0, bk[i], 6'h00), 1'b0);
			check("refresh_bank", refresh_bank, bk[i]);
			check("refresh_row", refresh_row, rw[i]);
		end
	endtask : t_refresh

	initial
	begin
		nrst = 1'b0;
		repeat (16) @(negedge clock);
		nrst = 1'b1;
		@(negedge clock);
		t_reset();
		t_bursts();
		t_mask();
		t_banks();
		t_refresh();
		end_of_test();
	end
endmodule : ddr_burst_memory_interface_bench
